// file: rtl/wdt_top.sv
// Watchdog interval timer with register file and expiry event logic
// Summary of operation
// - Counter steps derive from the 32 kHz clock
// - Register accesses finish on host clock, no waits
// - No pins; only registers and event outputs
// - System reset restores every default value except the history bit
// - Kept bits use only the kept reset
// - Expiry pulse: interrupt if bit 9, else reset
// - Latched expiry stays until system reset
// - Load reload value, then set enable
// - Clearing enable stops and gates the counter
// - Missed reload underflows and raises the event
// - Reload on load write, kick or expiry
// - One count per 33 slow clock periods
// - Enabled stall inputs freeze the count
// - After stall counting resumes without reload
// - Reload field 16 bits, resets FFFFh, reloads
// - Six registers at 00h to 14h
// - Kick reads zero, works only when enabled
// - Count register read-only, resets FFFFh
// - Status bit 0 flag, write one clears
// - Interrupt enable bit 0
`timescale 1ns/10ps
`default_nettype none
module wdt_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rst_keep_n,
  input wire logic slow_clk_in,
  input wire logic stall_jtag,
  input wire logic stall_week,
  input wire logic stall_hib,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic expiry_event,
  output logic expiry_reset_req,
  output logic expiry_interrupt
);
  // Address match helper shared by all decodes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Reset synchronisers, asynchronous assert and clocked release
  logic rst_meta_q;
  logic rst_n; // System reset used by the logic
  logic keep_meta_q;
  logic keep_n; // Reset that survives an expiry

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_keep_n) begin
    if (!rst_keep_n) begin
      keep_meta_q <= 1'b0;
      keep_n <= 1'b0;
    end else begin
      keep_meta_q <= 1'b1;
      keep_n <= keep_meta_q;
    end
  end

  // Stall inputs come from other blocks, so they are synchronised
  logic [2:0] stall_meta_q;
  logic [2:0] stall_sync_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stall_meta_q <= 3'h0;
      stall_sync_q <= 3'h0;
    end else begin
      stall_meta_q <= {stall_jtag, stall_week, stall_hib};
      stall_sync_q <= stall_meta_q;
    end
  end

  // Software visible state
  logic [15:0] reload_q; // Reload value
  logic [15:0] count_q; // Running count
  logic en_q; // Timer enable
  logic [2:0] stall_en_q; // {jtag, week, hib} stall enables
  logic sel_q; // Expiry selects interrupt when set
  logic flag_q; // Interrupt flag, write one clears
  logic latch_q; // Expiry seen since system reset
  logic hist_q; // Expiry seen since kept reset
  logic ien_q; // Interrupt enable
  logic [31:0] rdata_q;
  logic event_q;
  logic rstreq_q;
  logic irq_q;
  wdt_pkg::wdt_state_e state_q;
  wdt_pkg::wdt_state_e state_d;

  wdt_tick_if tk ();

  // Prescaler on the sampled slow clock
  wdt_tick #(.DIV(wdt_pkg::SLOW_PER_COUNT)) u_tick (
    .clk(clk_sys),
    .rst_n(rst_n),
    .slow_clk(slow_clk_in),
    .tk(tk)
  );

  // Write decode
  wire wr_reload = reg_wr & hit(reg_addr, wdt_pkg::OFS_RELOAD);
  wire wr_ctl = reg_wr & hit(reg_addr, wdt_pkg::OFS_CTRL);
  wire wr_kick = reg_wr & hit(reg_addr, wdt_pkg::OFS_KICK);
  wire wr_sts = reg_wr & hit(reg_addr, wdt_pkg::OFS_STATUS);
  wire wr_ien = reg_wr & hit(reg_addr, wdt_pkg::OFS_IEN);

  // Enable and stall as they will stand after this cycle
  wire en_d = wr_ctl ? reg_wdata[wdt_pkg::CTL_EN_BIT] : en_q;
  wire [2:0] stall_en_d = wr_ctl ? {reg_wdata[wdt_pkg::CTL_JTAG_BIT],
    reg_wdata[wdt_pkg::CTL_WEEK_BIT], reg_wdata[wdt_pkg::CTL_HIB_BIT]} : stall_en_q;
  wire stall_any = |(stall_sync_q & stall_en_d);
  wire running = (state_q == wdt_pkg::WDT_RUN);

  // Reload sources
  wire kick_ok = wr_kick & en_q;
  wire underflow = running & tk.tick & (count_q == 16'h0000);
  wire reload_now = wr_reload | kick_ok | underflow;
  wire dec_now = running & tk.tick;
  wire int_mode = underflow & sel_q;

  // Flag next value: a new expiry beats a same-cycle clear
  wire flag_clr = wr_sts & reg_wdata[wdt_pkg::STS_FLAG_BIT];
  wire flag_d = (flag_q & ~flag_clr) | int_mode;
  wire hist_clr = wr_sts & reg_wdata[wdt_pkg::STS_HIST_BIT];

  // Prescaler runs only while counting; restarts on every reload
  assign tk.run = running & ~stall_any;
  assign tk.restart = reload_now;

  // State selection: disabled, stalled or counting
  always_comb begin
    state_d = state_q;
    case (state_q)
      wdt_pkg::WDT_OFF: begin
        if (en_d) begin
          state_d = stall_any ? wdt_pkg::WDT_STALL : wdt_pkg::WDT_RUN;
        end
      end
      wdt_pkg::WDT_RUN, wdt_pkg::WDT_STALL: begin
        if (!en_d) begin
          state_d = wdt_pkg::WDT_OFF;
        end else if (stall_any) begin
          state_d = wdt_pkg::WDT_STALL;
        end else begin
          state_d = wdt_pkg::WDT_RUN;
        end
      end
      default: state_d = wdt_pkg::WDT_OFF;
    endcase
  end

  // Read mux; kick, reserved bits and holes read zero
  wire [31:0] rd_ctl = {22'h000000, sel_q, 4'h0, stall_en_q, 1'b0, en_q};
  wire [31:0] rd_sts = {29'h00000000, hist_q, latch_q, flag_q};
  wire [31:0] rdata_d =
    hit(reg_addr, wdt_pkg::OFS_RELOAD) ? {16'h0000, reload_q} :
    hit(reg_addr, wdt_pkg::OFS_CTRL) ? rd_ctl :
    hit(reg_addr, wdt_pkg::OFS_COUNT) ? {16'h0000, count_q} :
    hit(reg_addr, wdt_pkg::OFS_STATUS) ? rd_sts :
    hit(reg_addr, wdt_pkg::OFS_IEN) ? {31'h00000000, ien_q} :
    32'h00000000;

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= wdt_pkg::RELOAD_RST;
      en_q <= 1'b0;
      stall_en_q <= 3'h0;
      sel_q <= 1'b0;
      ien_q <= 1'b0;
    end else begin
      if (wr_reload) begin
        reload_q <= reg_wdata[15:0];
      end
      en_q <= en_d;
      stall_en_q <= stall_en_d;
      // Interrupt mode is used up by the expiry it served
      if (int_mode) begin
        sel_q <= 1'b0;
      end else if (wr_ctl) begin
        sel_q <= reg_wdata[wdt_pkg::CTL_SEL_BIT];
      end
      if (wr_ien) begin
        ien_q <= reg_wdata[wdt_pkg::IEN_BIT];
      end
    end
  end

  // Counter; a reload write loads the written value at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= wdt_pkg::COUNT_RST;
      state_q <= wdt_pkg::WDT_OFF;
    end else begin
      state_q <= state_d;
      if (wr_reload) begin
        count_q <= reg_wdata[15:0];
      end else if (reload_now) begin
        count_q <= reload_q;
      end else if (dec_now) begin
        count_q <= count_q - 16'h0001;
      end
    end
  end

  // Status, event outputs and read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      latch_q <= 1'b0;
      event_q <= 1'b0;
      rstreq_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      flag_q <= flag_d;
      latch_q <= latch_q | underflow;
      event_q <= underflow;
      rstreq_q <= underflow & ~sel_q;
      irq_q <= flag_q & ien_q;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // History bit lives on the reset that an expiry does not pull
  always_ff @(posedge clk_sys or negedge keep_n) begin
    if (!keep_n) begin
      hist_q <= 1'b0;
    end else begin
      hist_q <= (hist_q & ~hist_clr) | underflow;
    end
  end

  assign reg_rdata = rdata_q;
  assign expiry_event = event_q;
  assign expiry_reset_req = rstreq_q;
  assign expiry_interrupt = irq_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  event_pulse_a: assert property (event_q |=> !event_q)
    else $error("expiry event longer than one cycle");
  reload_write_a: assert property (wr_reload |=> count_q == $past(reg_wdata[15:0]))
    else $error("reload write did not load count");
  kick_idle_a: assert property (wr_kick && !en_q |=> $stable(count_q))
    else $error("kick changed count while disabled");
  stall_hold_a: assert property ((state_q == wdt_pkg::WDT_STALL) && !reload_now |=> $stable(count_q))
    else $error("count moved during stall");
  count_step_a: assert property (dec_now && !reload_now |=> count_q == $past(count_q) - 16'h0001)
    else $error("count did not step by one");
  underflow_reload_a: assert property (underflow && !wr_reload |=> event_q && count_q == $past(reload_q))
    else $error("underflow did not reload and signal");
  irq_select_a: assert property (int_mode |=> flag_q && !sel_q && !rstreq_q)
    else $error("interrupt mode expiry mishandled");
  irq_gate_a: assert property (flag_q && ien_q |=> irq_q)
    else $error("interrupt not raised");
  latch_keep_a: assert property (latch_q |=> latch_q)
    else $error("latched expiry lost");
  off_gate_a: assert property (!en_q |-> !tk.run)
    else $error("prescaler running while disabled");
endmodule
`default_nettype wire

// file: rtl/wdt_pkg.sv
// Package with register map, field positions and reset values of the watchdog
package wdt_pkg;
  // Register offsets
  localparam logic [7:0] OFS_RELOAD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_KICK = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IEN = 8'h14;
  // Control register fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_HIB_BIT = 2;
  localparam int CTL_WEEK_BIT = 3;
  localparam int CTL_JTAG_BIT = 4;
  localparam int CTL_SEL_BIT = 9;
  // Status register fields
  localparam int STS_FLAG_BIT = 0;
  localparam int STS_LATCH_BIT = 1;
  localparam int STS_HIST_BIT = 2;
  // Interrupt enable field
  localparam int IEN_BIT = 0;
  // Widths and reset values
  localparam int CNT_W = 16;
  localparam logic [15:0] RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'hFFFF;
  // Slow clock periods per count step
  localparam int SLOW_PER_COUNT = 33;
  // Counter state
  typedef enum logic [1:0] {WDT_OFF, WDT_RUN, WDT_STALL} wdt_state_e;
endpackage

// file: rtl/wdt_tick_if.sv
// Interface carrying run, restart and tick between core and prescaler
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
  logic run;     // Prescaler may advance
  logic restart; // Clear prescaler phase
  logic tick;    // One count step elapsed
  modport gen (input run, input restart, output tick);
  modport ctl (output run, output restart, input tick);
endinterface
`default_nettype wire

// file: rtl/wdt_tick.sv
// Prescaler: samples the 32 kHz clock and emits one tick per count step
`timescale 1ns/10ps
`default_nettype none
module wdt_tick #(
  parameter int DIV = wdt_pkg::SLOW_PER_COUNT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow_clk,
  wdt_tick_if.gen tk
);
  logic s1_q; // Synchroniser first stage
  logic s2_q; // Synchroniser second stage
  logic s3_q; // Previous synchronised level
  logic [5:0] div_q; // Slow edges seen in this step
  logic tick_q;
  wire rise = s2_q & ~s3_q; // Rising edge of the slow clock
  wire last = (div_q == 6'(DIV - 1));

  // Slow clock sampled as data; the gate of the whole counter chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      s1_q <= slow_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
      tick_q <= tk.run & rise & last & ~tk.restart;
      if (tk.restart) begin
        div_q <= 6'h00;
      end else if (tk.run && rise) begin
        div_q <= last ? 6'h00 : div_q + 6'h01;
      end
    end
  end
  assign tk.tick = tick_q;

  // Ticks are single cycles and only come while running
  tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick_q |=> !tick_q) else $error("tick longer than a cycle");
  tick_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tk.run |=> !tick_q) else $error("tick while gated");
endmodule
`default_nettype wire

// file: testbench/wdt_slow_src.sv
// Partner model: the low-speed clock source that feeds the watchdog
`timescale 1ns/10ps
`default_nettype none
module wdt_slow_src #(
  parameter int HALF_NS = 160 // Scaled-up slow clock so the run stays short
) (
  output logic slow_clk
);
  // Free-running source; the 7 ns offset keeps its edges off the host clock edges
  initial begin
    slow_clk = 1'b0;
    #7;
    forever #(HALF_NS) slow_clk = ~slow_clk;
  end
endmodule
`default_nettype wire

// file: testbench/watchdog_interval_timer_test.sv
// Self-checking testbench for the watchdog interval timer
`timescale 1ns/10ps
`default_nettype none
module watchdog_interval_timer_test;
  `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("Error %0t: got %h exp %h", $time, a, e); end end
  logic clk_sys, arst_n, rst_keep_n, slow_clk_in, stall_jtag, stall_week, stall_hib, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d; // Bus lines and last read word
  logic expiry_event, expiry_reset_req, expiry_interrupt;
  int fails, n_checks, cyc, t0, i;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] v;} wdt_row_s; // Write or read-and-expect
  wdt_row_s rows[16] = '{
    '{1'b0, 8'h00, 32'h0000FFFF}, '{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h08, 32'h0}, '{1'b0, 8'h0C, 32'h0000FFFF},
    '{1'b0, 8'h10, 32'h0}, '{1'b0, 8'h14, 32'h0}, '{1'b0, 8'h18, 32'h0},
    '{1'b1, 8'h00, 32'hFFFF1234}, '{1'b0, 8'h00, 32'h00001234}, '{1'b0, 8'h0C, 32'h00001234},
    '{1'b1, 8'h0C, 32'h00005555}, '{1'b0, 8'h0C, 32'h00001234}, '{1'b1, 8'h14, 32'hFFFFFFFF},
    '{1'b0, 8'h14, 32'h1}, '{1'b1, 8'h14, 32'h0}, '{1'b1, 8'h18, 32'hFFFFFFFF}};
  wdt_top u_wdt_top (.clk_sys(clk_sys), .arst_n(arst_n), .rst_keep_n(rst_keep_n), .slow_clk_in(slow_clk_in),
    .stall_jtag(stall_jtag), .stall_week(stall_week), .stall_hib(stall_hib), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .expiry_event(expiry_event), .expiry_reset_req(expiry_reset_req), .expiry_interrupt(expiry_interrupt));
  wdt_slow_src u_wdt_slow_src (.slow_clk(slow_clk_in));
  // Host clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Verdict and end of run, reached from the main sequence or the hang guard
  task automatic close_out();
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One-cycle write strobe; effect lands at the sampling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is registered at the sampling edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Poll the count until it shows a value, bounded
  task automatic wait_cnt(input logic [15:0] e);
    int k;
    k = 0;
    rd(wdt_pkg::OFS_COUNT);
    while (d !== {16'h0, e} && k < 400) begin
      rd(wdt_pkg::OFS_COUNT);
      k++;
    end
  endtask
  // Wait for the one-cycle expiry pulse, bounded
  task automatic wait_evt();
    int k;
    k = 0;
    while (expiry_event !== 1'b1 && k < 1500) begin
      @(posedge clk_sys);
      #1 k++;
    end
    `CHK(expiry_event, 1'b1)
  endtask
  // Hang guard: the whole run needs well under 6000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    {arst_n, rst_keep_n, stall_jtag, stall_hib, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata, d, fails, n_checks, cyc} = '0;
    stall_week = 1'b1; // Active but not enabled: must not stall
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1; rst_keep_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    // Table of plain accesses: reset values, masks, refused writes, unmapped place
    for (i = 0; i < 16; i++) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].v);
      else begin
        rd(rows[i].a);
        `CHK(d, rows[i].v)
      end
    end
    // Load then enable; steps spaced 33 slow periods of 8 host cycles
    wr(wdt_pkg::OFS_RELOAD, 32'h5);
    wr(wdt_pkg::OFS_CTRL, 32'h1);
    wait_cnt(16'h4);
    t0 = cyc;
    wait_cnt(16'h3);
    `CHK((cyc - t0 >= 262 && cyc - t0 <= 266), 1'b1)
    // Enabled stall freezes, release resumes without reload
    stall_hib <= 1'b1;
    wr(wdt_pkg::OFS_CTRL, 32'h5);
    repeat (600) @(posedge clk_sys);
    rd(wdt_pkg::OFS_COUNT);
    `CHK(d, 32'h3)
    stall_hib <= 1'b0;
    wait_cnt(16'h2);
    `CHK(d, 32'h2)
    // Disabled: frozen, kick ignored; enabled kick reloads
    wr(wdt_pkg::OFS_CTRL, 32'h0);
    repeat (600) @(posedge clk_sys);
    wr(wdt_pkg::OFS_KICK, 32'hA5);
    rd(wdt_pkg::OFS_COUNT);
    `CHK(d, 32'h2)
    wr(wdt_pkg::OFS_CTRL, 32'h1);
    wr(wdt_pkg::OFS_KICK, 32'hA5);
    rd(wdt_pkg::OFS_COUNT);
    `CHK(d, 32'h5)
    // Expiry in interrupt mode
    wr(wdt_pkg::OFS_RELOAD, 32'h1);
    wr(wdt_pkg::OFS_IEN, 32'h1);
    wr(wdt_pkg::OFS_CTRL, 32'h201);
    wait_evt();
    `CHK(expiry_reset_req, 1'b0)
    repeat (2) @(posedge clk_sys);
    #1 `CHK(expiry_interrupt, 1'b1)
    rd(wdt_pkg::OFS_STATUS);
    `CHK(d[1:0], 2'b11)
    rd(wdt_pkg::OFS_CTRL);
    `CHK(d, 32'h1)
    rd(wdt_pkg::OFS_COUNT);
    `CHK(d, 32'h1)
    wr(wdt_pkg::OFS_IEN, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(expiry_interrupt, 1'b0)
    wr(wdt_pkg::OFS_STATUS, 32'h1);
    wr(wdt_pkg::OFS_IEN, 32'h1);
    rd(wdt_pkg::OFS_STATUS);
    `CHK(d[1:0], 2'b10)
    `CHK(expiry_interrupt, 1'b0)
    // Expiry in reset mode, then system reset and kept reset
    wait_evt();
    `CHK(expiry_reset_req, 1'b1)
    wr(wdt_pkg::OFS_CTRL, 32'h0);
    rd(wdt_pkg::OFS_STATUS);
    `CHK(d[1], 1'b1)
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(wdt_pkg::OFS_STATUS);
    `CHK(d, 32'h4)
    rd(wdt_pkg::OFS_RELOAD);
    `CHK(d, 32'hFFFF)
    rd(wdt_pkg::OFS_COUNT);
    `CHK(d, 32'hFFFF)
    rst_keep_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_keep_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(wdt_pkg::OFS_STATUS);
    `CHK(d, 32'h0)
    close_out();
  end
endmodule
`default_nettype wire
